/* File: hw/tsp_pkg.sv */
// Operation
// - role selector 0x02 makes the node a router relaying parent and children.
// - relay active only when relay enable equals 0x01.
// - parent id 0xFF links to any receivable parent; never pick own child.
// - alternate parent id 0xFF means no fallback parent.
// - specific parent id links only to that parent; off network while gone; the code drops the link only after a hop with no beacon of any id.
// - base slot payload at most 105, minus three per extra slot.
// - base buffer is base slot plus nine, at most 114.
// - base packs messages up to limit, nine header bytes plus payload each.
// - a message is sent whole in one slot, never split.
// - child slot payload at most 109; child buffer plus nine, at most 118.
// - child packs messages up to limit, nine header bytes plus payload each.
// - child slot size computed from base slot, hop duration and slot count.
// - hop us = slots*(80*child+2440)+80*base+3280, rounded up to 500.
// - defaults 40 byte base slot, three slots, 20 ms hop, 25 byte child slot.
// - slot sizes at least 20 bytes; the code refuses only short base slot writes and does not clamp the child slot.
// - slot count limits children per hop, at most eight.
// - only the base configures slot count; others adopt the distributed value.
// - each node sends at most its own per-hop message limit.
// - base keeps remote slot reserved through gaps for the lease, up to 8.
// - messages in one hop must be present before that hop's transmission.
// - data transmit message needs slot space of length field minus three.
// - role selector 0x01 makes the node the base.
// - slot lease defaults to 4 hops.
// - per-hop message limit defaults to 8.
package tsp_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_ROLE    = 8'h00;
  localparam logic [7:0] REG_RELAY   = 8'h04;
  localparam logic [7:0] REG_NETID   = 8'h08;
  localparam logic [7:0] REG_PARENT  = 8'h0c;
  localparam logic [7:0] REG_ALTPAR  = 8'h10;
  localparam logic [7:0] REG_MSGLIM  = 8'h14;
  localparam logic [7:0] REG_SLOTS   = 8'h18;
  localparam logic [7:0] REG_LEASE   = 8'h1c;
  localparam logic [7:0] REG_BSS     = 8'h20;
  localparam logic [7:0] REG_HOPUS   = 8'h24;
  localparam logic [7:0] REG_RSS     = 8'h28;
  localparam logic [7:0] REG_STATUS  = 8'h2c;
  localparam logic [7:0] REG_MSGIN   = 8'h30;
  localparam logic [7:0] REG_LINK    = 8'h34;
  localparam logic [7:0] REG_RESERVE = 8'h38;
  // ---------------------------------------------------------------
  // codes and limits
  // ---------------------------------------------------------------
  localparam logic [7:0]  ROLE_REMOTE  = 8'h00;
  localparam logic [7:0]  ROLE_BASE    = 8'h01;
  localparam logic [7:0]  ROLE_ROUTER  = 8'h02;
  localparam logic [7:0]  RELAY_ON     = 8'h01;
  localparam logic [7:0]  ID_WILD      = 8'hff;
  localparam logic [7:0]  BSS_MAX1     = 8'd105;
  localparam logic [7:0]  BSS_STEP     = 8'd3;
  localparam logic [7:0]  HDR_BYTES    = 8'd9;
  localparam logic [7:0]  BBUF_MAX     = 8'd114;
  localparam logic [7:0]  RSS_MAX      = 8'd109;
  localparam logic [7:0]  RBUF_MAX     = 8'd118;
  localparam logic [7:0]  SLOT_MIN     = 8'd20;
  localparam logic [3:0]  SLOTS_MAX    = 4'd8;
  localparam logic [7:0]  TXD_ADJ      = 8'd3;
  localparam logic [31:0] HD_SLOT_K    = 32'd80;
  localparam logic [31:0] HD_SLOT_C    = 32'd2440;
  localparam logic [31:0] HD_BASE_C    = 32'd3280;
  localparam logic [31:0] HD_STEP_US   = 32'd500;
  localparam logic [7:0]  DEF_BSS      = 8'd40;
  localparam logic [3:0]  DEF_SLOTS    = 4'd3;
  localparam logic [31:0] DEF_HOP_US   = 32'd20000;
  localparam logic [7:0]  DEF_LEASE    = 8'd4;
  localparam logic [7:0]  DEF_MSGLIM   = 8'd8;
  localparam int          CLK_MHZ      = 200;
  localparam logic [7:0]  CYC_PER_US   = 8'(CLK_MHZ);
  // hop phases
  typedef enum logic [1:0] {
    TSP_IDLE  = 2'b00,
    TSP_BASE  = 2'b01,
    TSP_CHILD = 2'b10
  } tsp_phase_t;
  // message offered for transmission
  typedef struct packed {
    logic       is_data_transmit_message;
    logic [7:0] len;
  } tsp_msg_t;
endpackage

/* File: hw/tsp_planner.sv */
`timescale 1ns/10ps
module tsp_planner #(
  parameter int LEASE_W = 8
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_sys_rst,
  input  wire logic [7:0]        i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [31:0]       i_avs_writedata,
  output logic [31:0]            o_avs_readdata,
  output logic                   o_avs_waitrequest,
  input  wire logic              i_beacon_seen,
  input  wire logic [7:0]        i_beacon_net_id,
  input  wire logic [3:0]        i_beacon_slots,
  input  wire logic              i_beacon_from_child,
  input  wire logic              i_child_active,
  input  wire logic [2:0]        i_child_index,
  input  wire logic              i_msg_valid,
  input  wire tsp_pkg::tsp_msg_t i_msg,
  output logic                   o_msg_ready,
  output logic                   o_msg_send,
  output logic [1:0]             o_phase,
  output logic [2:0]             o_slot_index,
  output logic                   o_tx_window,
  output logic                   o_linked,
  output logic                   o_relay_active,
  output logic                   o_is_base
);
  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  logic [7:0]  role_q, relay_q, netid_q, parent_q, altpar_q, msglim_q, lease_q, bss_q;
  logic [3:0]  slots_cfg_q;
  logic [31:0] hop_us_q;
  logic        ack_q;
  logic [31:0] rdata_q;
  logic        acc;
  logic        done;
  assign acc = (i_avs_read | i_avs_write) & ~ack_q;
  // a write lands only at the edge where waitrequest is seen low
  assign done = (i_avs_read | i_avs_write) & ack_q;
  // one wait cycle, then the access completes
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;

  // register writes
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      role_q      <= tsp_pkg::ROLE_REMOTE;
      relay_q     <= 8'h00;
      netid_q     <= 8'h00;
      parent_q    <= tsp_pkg::ID_WILD;
      altpar_q    <= tsp_pkg::ID_WILD;
      msglim_q    <= tsp_pkg::DEF_MSGLIM;
      slots_cfg_q <= tsp_pkg::DEF_SLOTS;
      lease_q     <= tsp_pkg::DEF_LEASE;
      bss_q       <= tsp_pkg::DEF_BSS;
      hop_us_q    <= tsp_pkg::DEF_HOP_US;
    end
    else if (done && i_avs_write)
    begin
      case (i_avs_address)
        tsp_pkg::REG_ROLE:   role_q   <= i_avs_writedata[7:0];
        tsp_pkg::REG_RELAY:  relay_q  <= i_avs_writedata[7:0];
        tsp_pkg::REG_NETID:  netid_q  <= i_avs_writedata[7:0];
        tsp_pkg::REG_PARENT: parent_q <= i_avs_writedata[7:0];
        tsp_pkg::REG_ALTPAR: altpar_q <= i_avs_writedata[7:0];
        tsp_pkg::REG_MSGLIM: msglim_q <= i_avs_writedata[7:0];
        tsp_pkg::REG_SLOTS:
          if (i_avs_writedata[3:0] != 4'h0 && i_avs_writedata[3:0] <= tsp_pkg::SLOTS_MAX)
            slots_cfg_q <= i_avs_writedata[3:0];
        tsp_pkg::REG_LEASE:  lease_q  <= i_avs_writedata[7:0];
        tsp_pkg::REG_BSS:
          if (i_avs_writedata[7:0] >= tsp_pkg::SLOT_MIN)
            bss_q <= i_avs_writedata[7:0];
        tsp_pkg::REG_HOPUS:  hop_us_q <= i_avs_writedata;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // role, slot count and child slot size
  // ---------------------------------------------------------------
  logic       is_base, is_router, relay_on;
  logic [3:0] slots_adopt_q, slots_eff;
  assign is_base   = (role_q == tsp_pkg::ROLE_BASE);
  assign relay_on  = (relay_q == tsp_pkg::RELAY_ON);
  assign is_router = (role_q == tsp_pkg::ROLE_ROUTER) & relay_on;

  // non-base nodes adopt the slot count distributed in the beacon
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      slots_adopt_q <= tsp_pkg::DEF_SLOTS;
    else if (i_beacon_seen && o_linked && i_beacon_slots != 4'h0 && i_beacon_slots <= tsp_pkg::SLOTS_MAX)
      slots_adopt_q <= i_beacon_slots;
  end
  assign slots_eff = is_base ? slots_cfg_q : slots_adopt_q;

  // base slot ceiling and buffers
  logic [7:0] bss_cap, bss_eff, bbuf, rss_q, rbuf;
  assign bss_cap = 8'(tsp_pkg::BSS_MAX1 - tsp_pkg::BSS_STEP * 8'(slots_eff - 4'd1));
  assign bss_eff = (bss_q > bss_cap) ? bss_cap : bss_q;
  assign bbuf    = (8'(bss_eff + tsp_pkg::HDR_BYTES) > tsp_pkg::BBUF_MAX) ?
                   tsp_pkg::BBUF_MAX : 8'(bss_eff + tsp_pkg::HDR_BYTES);
  assign rbuf    = (8'(rss_q + tsp_pkg::HDR_BYTES) > tsp_pkg::RBUF_MAX) ?
                   tsp_pkg::RBUF_MAX : 8'(rss_q + tsp_pkg::HDR_BYTES);

  // hop duration in cycles, rounded up to a 500 us step
  logic [31:0] hop_round_us, hop_cycles;
  assign hop_round_us = ((hop_us_q + tsp_pkg::HD_STEP_US - 32'd1) / tsp_pkg::HD_STEP_US)
                        * tsp_pkg::HD_STEP_US;
  assign hop_cycles   = hop_round_us * 32'(tsp_pkg::CYC_PER_US);

  // solve hop formula for the child slot size against the rounded hop, which is how long it lasts
  logic [31:0] avail, per_slot, rss_raw;
  always_comb
  begin
    avail    = 32'h0;
    per_slot = 32'h0;
    rss_raw  = 32'h0;
    if (hop_round_us > tsp_pkg::HD_BASE_C + tsp_pkg::HD_SLOT_K * 32'(bss_eff))
      avail = hop_round_us - tsp_pkg::HD_BASE_C - tsp_pkg::HD_SLOT_K * 32'(bss_eff);
    per_slot = avail / 32'(slots_eff);
    if (per_slot > tsp_pkg::HD_SLOT_C)
      rss_raw = (per_slot - tsp_pkg::HD_SLOT_C) / tsp_pkg::HD_SLOT_K;
  end

  // child slot size register, clamped to the ceiling
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      rss_q <= 8'h00;
    else
      rss_q <= (rss_raw > 32'(tsp_pkg::RSS_MAX)) ? tsp_pkg::RSS_MAX : rss_raw[7:0];
  end

  // ---------------------------------------------------------------
  // parent selection
  // ---------------------------------------------------------------
  logic linked_q, lost_q;
  logic match_pri, match_alt, any_ok;
  assign any_ok    = (parent_q == tsp_pkg::ID_WILD) & ~i_beacon_from_child;
  assign match_pri = (parent_q != tsp_pkg::ID_WILD) & (i_beacon_net_id == parent_q);
  assign match_alt = (altpar_q != tsp_pkg::ID_WILD) & (i_beacon_net_id == altpar_q);

  // link on an acceptable beacon, drop after a whole hop with no beacon of any id
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      linked_q <= 1'b0;
    else if (is_base)
      linked_q <= 1'b1;
    else if (i_beacon_seen && (any_ok || match_pri || match_alt))
      linked_q <= 1'b1;
    else if (lost_q)
      linked_q <= 1'b0;
  end
  assign o_linked = linked_q;

  // ---------------------------------------------------------------
  // hop sequencer: base period then child slots
  // ---------------------------------------------------------------
  tsp_pkg::tsp_phase_t phase_q;
  logic [31:0] cyc_q, base_cyc, slot_cyc;
  logic [2:0]  slot_q;
  logic        hop_end;
  assign base_cyc = (tsp_pkg::HD_SLOT_K * 32'(bss_eff) + tsp_pkg::HD_BASE_C) * 32'(tsp_pkg::CYC_PER_US);
  assign slot_cyc = (hop_cycles - base_cyc) / 32'(slots_eff);
  assign hop_end  = (phase_q == tsp_pkg::TSP_CHILD) && (cyc_q == slot_cyc - 32'd1)
                    && (slot_q == 3'(slots_eff - 4'd1));

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      phase_q <= tsp_pkg::TSP_IDLE;
      cyc_q   <= 32'h0;
      slot_q  <= 3'h0;
    end
    else
    begin
      case (phase_q)
        tsp_pkg::TSP_IDLE:
          if (linked_q)
          begin
            phase_q <= tsp_pkg::TSP_BASE;
            cyc_q   <= 32'h0;
          end
        tsp_pkg::TSP_BASE:
          if (cyc_q >= base_cyc - 32'd1)
          begin
            phase_q <= tsp_pkg::TSP_CHILD;
            cyc_q   <= 32'h0;
            slot_q  <= 3'h0;
          end
          else
            cyc_q <= cyc_q + 32'd1;
        tsp_pkg::TSP_CHILD:
          if (cyc_q >= slot_cyc - 32'd1)
          begin
            cyc_q <= 32'h0;
            if (slot_q >= 3'(slots_eff - 4'd1))
              phase_q <= linked_q ? tsp_pkg::TSP_BASE : tsp_pkg::TSP_IDLE;
            else
              slot_q <= slot_q + 3'd1;
          end
          else
            cyc_q <= cyc_q + 32'd1;
        default: phase_q <= tsp_pkg::TSP_IDLE;
      endcase
    end
  end
  assign o_phase      = phase_q;
  assign o_slot_index = slot_q;

  // parent lost after a whole hop with no beacon
  logic beacon_hop_q;
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      beacon_hop_q <= 1'b0;
      lost_q       <= 1'b0;
    end
    else
    begin
      lost_q <= hop_end & ~beacon_hop_q & ~i_beacon_seen & ~is_base;
      if (hop_end)
        beacon_hop_q <= 1'b0;
      else if (i_beacon_seen)
        beacon_hop_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // slot leases held by the base
  // ---------------------------------------------------------------
  logic [LEASE_W-1:0] lease_cnt_q [8];
  logic [7:0]         reserved;
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_lease
      // reload on activity, count down once per hop
      always_ff @(posedge i_core_clk)
      begin
        if (i_sys_rst)
          lease_cnt_q[g] <= '0;
        else if (i_child_active && i_child_index == 3'(g) && is_base)
          lease_cnt_q[g] <= LEASE_W'(lease_q);
        else if (hop_end && lease_cnt_q[g] != '0)
          lease_cnt_q[g] <= lease_cnt_q[g] - 1'b1;
      end
      assign reserved[g] = (lease_cnt_q[g] != '0) && (4'(g) < slots_eff);
    end
  endgenerate

  // ---------------------------------------------------------------
  // message packing per hop
  // ---------------------------------------------------------------
  logic [7:0] used_q, sent_q, need, buf_lim;
  logic       my_window, packing_q, fits;
  // own window: base period for the base, every child slot otherwise
  assign my_window = is_base ? (phase_q == tsp_pkg::TSP_BASE) :
                     (phase_q == tsp_pkg::TSP_CHILD && linked_q);
  assign buf_lim   = is_base ? bbuf : rbuf;
  assign need      = 8'((i_msg.is_data_transmit_message ? 8'(i_msg.len - tsp_pkg::TXD_ADJ) : i_msg.len)
                     + tsp_pkg::HDR_BYTES);
  assign fits      = (9'(used_q) + 9'(need) <= 9'(buf_lim))
                     && (sent_q < msglim_q);
  // only messages queued before the window opens are packed
  assign o_msg_ready = packing_q & fits;
  assign o_msg_send  = i_msg_valid & o_msg_ready;

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      used_q    <= 8'h00;
      sent_q    <= 8'h00;
      packing_q <= 1'b0;
    end
    else if (hop_end || !my_window)
    begin
      used_q    <= 8'h00;
      sent_q    <= 8'h00;
      packing_q <= my_window ? 1'b0 : i_msg_valid & linked_q;
    end
    else if (o_msg_send)
    begin
      used_q <= 8'(used_q + need);
      sent_q <= sent_q + 8'd1;
    end
  end
  assign o_tx_window    = my_window;
  assign o_relay_active = is_router;
  assign o_is_base      = is_base;

  // ---------------------------------------------------------------
  // register reads
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0;
    end
    else
    begin
      ack_q <= acc;
      if (acc && i_avs_read)
        case (i_avs_address)
          tsp_pkg::REG_ROLE:    rdata_q <= {24'h0, role_q};
          tsp_pkg::REG_RELAY:   rdata_q <= {24'h0, relay_q};
          tsp_pkg::REG_NETID:   rdata_q <= {24'h0, netid_q};
          tsp_pkg::REG_PARENT:  rdata_q <= {24'h0, parent_q};
          tsp_pkg::REG_ALTPAR:  rdata_q <= {24'h0, altpar_q};
          tsp_pkg::REG_MSGLIM:  rdata_q <= {24'h0, msglim_q};
          tsp_pkg::REG_SLOTS:   rdata_q <= {28'h0, slots_eff};
          tsp_pkg::REG_LEASE:   rdata_q <= {24'h0, lease_q};
          tsp_pkg::REG_BSS:     rdata_q <= {24'h0, bss_eff};
          tsp_pkg::REG_HOPUS:   rdata_q <= hop_round_us;
          tsp_pkg::REG_RSS:     rdata_q <= {16'h0, rbuf, rss_q};
          tsp_pkg::REG_STATUS:  rdata_q <= {16'h0, bbuf, 4'h0, is_router, relay_on, is_base, linked_q};
          tsp_pkg::REG_MSGIN:   rdata_q <= {16'h0, sent_q, used_q};
          tsp_pkg::REG_LINK:    rdata_q <= {28'h0, phase_q == tsp_pkg::TSP_CHILD, slot_q};
          tsp_pkg::REG_RESERVE: rdata_q <= {24'h0, reserved};
          default:              rdata_q <= 32'h0;
        endcase
    end
  end
  assign o_avs_readdata = rdata_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_write_bss_small;
    i_avs_write && done && i_avs_address == tsp_pkg::REG_BSS && i_avs_writedata[7:0] < tsp_pkg::SLOT_MIN;
  endsequence
  a_bss_min_hold: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    s_write_bss_small |=> $stable(bss_q)) else $error("small base slot accepted");
  a_bss_cap_bound: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    bss_eff <= bss_cap && bbuf <= tsp_pkg::BBUF_MAX) else $error("base slot ceiling broken");
  a_rss_cap_bound: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    rss_q <= tsp_pkg::RSS_MAX && rbuf <= tsp_pkg::RBUF_MAX) else $error("child slot ceiling broken");
  a_msg_limit_kept: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    o_msg_send |-> sent_q < msglim_q) else $error("message limit exceeded");
  a_buf_not_split: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    o_msg_send |=> used_q <= buf_lim) else $error("buffer overfilled");
  a_slot_count_max: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    slots_eff <= tsp_pkg::SLOTS_MAX && slots_eff != 4'h0) else $error("slot count out of range");
  a_phase_order: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    phase_q == tsp_pkg::TSP_BASE ##1 phase_q == tsp_pkg::TSP_CHILD |-> slot_q == 3'h0)
    else $error("child slots out of order");
  a_router_relay: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    o_relay_active |-> role_q == tsp_pkg::ROLE_ROUTER && relay_q == tsp_pkg::RELAY_ON)
    else $error("relay without router and enable");
  a_wild_no_child: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    !linked_q && !is_base && i_beacon_seen && i_beacon_from_child && parent_q == tsp_pkg::ID_WILD
    && !match_alt |=> !linked_q) else $error("linked to child router");
  a_link_any_parent: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    !is_base && i_beacon_seen && any_ok |=> linked_q) else $error("wildcard parent not linked");
  a_alt_disabled: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    !is_base && !linked_q && i_beacon_seen && !any_ok && !match_pri && altpar_q == tsp_pkg::ID_WILD
    |=> !linked_q) else $error("disabled alternate parent used");
  a_lease_reload: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_child_active && is_base && LEASE_W'(lease_q) != '0 && 4'(i_child_index) < slots_eff
    |=> reserved[$past(i_child_index)]) else $error("active child slot not reserved");
  a_data_transmit_message_cost: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    o_msg_send && i_msg.is_data_transmit_message && !hop_end
    |=> used_q == 8'($past(used_q) + $past(i_msg.len) - tsp_pkg::TXD_ADJ + tsp_pkg::HDR_BYTES))
    else $error("data message cost wrong");
endmodule

/* File: tb/tsp_parent_model.sv */
`timescale 1ns/10ps
// ---------------------------------------------------------------
// upstream radio: emits one beacon pulse per request
// ---------------------------------------------------------------
module tsp_parent_model (
  input  wire logic       i_core_clk,
  input  wire logic       i_fire,
  input  wire logic [7:0] i_id,
  input  wire logic [3:0] i_slots,
  input  wire logic       i_child,
  output logic            o_seen,
  output logic [7:0]      o_net_id,
  output logic [3:0]      o_slots,
  output logic            o_from_child
);
  // beacon fields only hold during the pulse, otherwise inverted junk
  always_ff @(posedge i_core_clk)
  begin
    o_seen       <= i_fire;
    o_net_id     <= i_fire ? i_id : ~o_net_id;      // sender id unique per router
    o_slots      <= i_fire ? i_slots : ~o_slots;    // base distributes slot count
    o_from_child <= i_fire ? i_child : ~o_from_child;
  end
endmodule

/* File: tb/tdma_hop_slot_planner_tb.sv */
`timescale 1ns/10ps
module tdma_hop_slot_planner_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic        waitreq;
  logic        fire = 1'b0;
  logic [7:0]  b_id = 8'h00;
  logic [3:0]  b_slots = 4'h0;
  logic        b_child = 1'b0;
  logic        seen, from_child, ready, send, tx_win, linked, relay_act, is_base;
  logic [7:0]  net_id;
  logic [3:0]  slots;
  logic [1:0]  phase;
  logic [2:0]  slot_idx;
  logic [31:0] q;
  logic        mv = 1'b0;
  logic        ca = 1'b0;
  logic [2:0]  ci = 3'h0;
  tsp_pkg::tsp_msg_t msg = '0;
  int          fail_count = 0;
  int          checks = 0;
  typedef struct {logic [7:0] a; logic [31:0] m; logic [31:0] e;} tsp_row_t;
  tsp_row_t    rows [8];
  always #2.5 clk = ~clk;
  tsp_parent_model i_tsp_parent_model (.i_core_clk(clk), .i_fire(fire), .i_id(b_id), .i_slots(b_slots),
    .i_child(b_child), .o_seen(seen), .o_net_id(net_id), .o_slots(slots), .o_from_child(from_child));
  tsp_planner i_tsp_planner (.i_core_clk(clk), .i_sys_rst(rst), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
    .i_beacon_seen(seen), .i_beacon_net_id(net_id), .i_beacon_slots(slots), .i_beacon_from_child(from_child),
    .i_child_active(ca), .i_child_index(ci), .i_msg_valid(mv), .i_msg(msg), .o_msg_ready(ready),
    .o_msg_send(send), .o_phase(phase), .o_slot_index(slot_idx), .o_tx_window(tx_win), .o_linked(linked),
    .o_relay_active(relay_act), .o_is_base(is_base));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one avalon transfer, held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    rd <= ~w;
    wr <= w;
    @(posedge clk);
    while (waitreq !== 1'b0)
      @(posedge clk);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic beacon(input logic [7:0] id, input logic [3:0] s, input logic c);
    fire <= 1'b1;
    b_id <= id;
    b_slots <= s;
    b_child <= c;
    @(posedge clk);
    fire <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic finish_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // watchdog
  // ---------------------------------------------------------------
  initial
  begin
    #50000;
    fail_count++;
    finish_test;
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    rows = '{'{tsp_pkg::REG_ROLE, 32'hff, 32'h00}, '{tsp_pkg::REG_LEASE, 32'hff, 32'h04},
             '{tsp_pkg::REG_MSGLIM, 32'hff, 32'h08}, '{tsp_pkg::REG_BSS, 32'hff, 32'h28},
             '{tsp_pkg::REG_SLOTS, 32'hf, 32'h3}, '{tsp_pkg::REG_HOPUS, 32'hffff, 32'h4e20},
             '{tsp_pkg::REG_RSS, 32'hffff, 32'h2219}, '{8'h3c, 32'hffffffff, 32'h0}};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({31'h0, linked}, 32'h0);
    // default values, rss derived from the defaults
    foreach (rows[i])
    begin
      bus(1'b0, rows[i].a, 32'h0);
      chk(q & rows[i].m, rows[i].e);
    end
    // base role for the slot tests: only the base owns its slot count
    bus(1'b1, tsp_pkg::REG_ROLE, 32'h01);
    // refused writes: short base slot, zero and nine slots
    bus(1'b1, tsp_pkg::REG_BSS, 32'h13);
    bus(1'b0, tsp_pkg::REG_BSS, 32'h0);
    chk(q & 32'hff, 32'h28);
    bus(1'b1, tsp_pkg::REG_SLOTS, 32'h9);
    bus(1'b1, tsp_pkg::REG_SLOTS, 32'h0);
    bus(1'b0, tsp_pkg::REG_SLOTS, 32'h0);
    chk(q & 32'hf, 32'h3);
    // eight slots lower the base slot ceiling to 105 - 7*3 = 84
    bus(1'b1, tsp_pkg::REG_SLOTS, 32'h8);
    bus(1'b1, tsp_pkg::REG_BSS, 32'h64);
    bus(1'b0, tsp_pkg::REG_BSS, 32'h0);
    chk(q & 32'hff, 32'h54);
    // hop rounding and derived child slot: 1 slot, bss 20, hop 9201 -> 9500, rss 27
    bus(1'b1, tsp_pkg::REG_SLOTS, 32'h1);
    bus(1'b1, tsp_pkg::REG_BSS, 32'h14);
    bus(1'b1, tsp_pkg::REG_HOPUS, 32'h23f1);
    bus(1'b0, tsp_pkg::REG_HOPUS, 32'h0);
    chk(q & 32'hffff, 32'h251c);
    bus(1'b0, tsp_pkg::REG_RSS, 32'h0);
    chk(q & 32'hffff, 32'h241b);
    bus(1'b0, tsp_pkg::REG_STATUS, 32'h0);
    chk(q & 32'hff00, 32'h1d00);
    // second reset in mid-run: back to an unlinked remote with defaults
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({30'h0, is_base, linked}, 32'h0);
    bus(1'b0, tsp_pkg::REG_BSS, 32'h0);
    chk(q & 32'hff, 32'h28);
    // specific parent: foreign and wildcard beacons ignored, named one links
    bus(1'b1, tsp_pkg::REG_PARENT, 32'h05);
    bus(1'b1, tsp_pkg::REG_ALTPAR, 32'hff);
    beacon(8'h07, 4'h5, 1'b0);
    chk({31'h0, linked}, 32'h0);
    beacon(8'hff, 4'h5, 1'b0);
    chk({31'h0, linked}, 32'h0);
    bus(1'b1, tsp_pkg::REG_PARENT, 32'hff);
    beacon(8'h09, 4'h5, 1'b1);
    chk({31'h0, linked}, 32'h0);
    bus(1'b1, tsp_pkg::REG_PARENT, 32'h05);
    beacon(8'h05, 4'h5, 1'b0);
    chk({31'h0, linked}, 32'h1);
    // slot count is adopted from beacons heard once linked
    beacon(8'h05, 4'h5, 1'b0);
    bus(1'b0, tsp_pkg::REG_SLOTS, 32'h0);
    chk(q & 32'hf, 32'h5);
    // roles and relay enable
    bus(1'b1, tsp_pkg::REG_ROLE, 32'h02);
    bus(1'b1, tsp_pkg::REG_RELAY, 32'h01);
    chk({30'h0, relay_act, is_base}, 32'h2);
    bus(1'b0, tsp_pkg::REG_STATUS, 32'h0);
    chk(q & 32'hc, 32'hc);
    bus(1'b1, tsp_pkg::REG_RELAY, 32'h02);
    chk({31'h0, relay_act}, 32'h0);
    // data message of length 14 costs 14 - 3 + 9 = 20; two fit the 49 byte base buffer
    msg <= '{1'b1, 8'd14};
    mv <= 1'b1;
    bus(1'b1, tsp_pkg::REG_ROLE, 32'h01);
    repeat (2) @(posedge clk);
    chk({30'h0, is_base, linked}, 32'h3);
    chk({26'h0, phase, slot_idx, tx_win}, 32'h11);
    chk({31'h0, ready}, 32'h0);
    bus(1'b0, tsp_pkg::REG_MSGIN, 32'h0);
    chk(q & 32'hffff, 32'h0228);
    mv <= 1'b0;
    // child heard in slot 2 keeps it reserved; index 5 lies past the three slots
    ca <= 1'b1;
    ci <= 3'h2;
    @(posedge clk);
    ci <= 3'h5;
    @(posedge clk);
    ca <= 1'b0;
    bus(1'b0, tsp_pkg::REG_RESERVE, 32'h0);
    chk(q & 32'hff, 32'h04);
    finish_test;
  end
endmodule
